// *** prt_regs.sv ***
// register bank, interrupt source and four transfer channels of two ports
//
// Behaviour
// (R1) Registers sit on a 32-bit peripheral bus.
// (R2) Only word access; low two address bits are ignored.
// (R3) Each port decodes a 16K window; interrupt controller window is 4K.
// (R4) Command register is write-only; ones trigger commands, zeros nothing.
// (R5) Configuration register is read/write and resets to zero.
// (R6) Status register is read-only and shows current state.
// (R7) Writing ones to a set register sets those state bits.
// (R8) Writing ones to a clear register clears bits, readable afterwards.
// (R9) Unused bits read zero; software writes them zero.
// (R10) Each status bit is ANDed with its mask bit; only the two end flags have mask bits here.
// (R11) Masked bits are ORed into one interrupt source per port.
// (R12) Mask is readable; changed only by mask-set and mask-clear writes.
// (R13) Four channels: receiver and transmitter of each serial port.
// (R14) Each channel has 32-bit pointer and 16-bit counter in its window.
// (R15) Finished channel sets an end flag in status, maskable interrupt.
// (R16) Each transfer advances pointer, decrements counter, stops at zero.
`timescale 1ns/100ps
module prt_regs (
	// clock, reset and enable
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// peripheral bus
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [14:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	// serial port transfer requests, bit 2p rx, 2p+1 tx
	input  wire logic [3:0]  xfer_req_i,
	// transfer acknowledges and addresses
	output logic      [3:0]  xfer_ack_o,
	output logic      [31:0] xfer_addr0_o,
	output logic      [31:0] xfer_addr1_o,
	output logic      [31:0] xfer_addr2_o,
	output logic      [31:0] xfer_addr3_o,
	// interrupt sources to the interrupt controller
	output logic      [1:0]  irq_src_o
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [1:0]  cfg_ff  [2];
	logic [1:0]  nxt_cfg [2];
	logic [1:0]  msk_ff  [2];
	logic [1:0]  nxt_msk [2];
	logic [1:0]  end_ff  [2];
	logic [1:0]  nxt_end [2];
	logic [1:0]  irq_ff, nxt_irq;
	logic [31:0] rd_ff, nxt_rd;
	// channel side
	logic [31:0] ch_ptr  [4];
	logic [15:0] ch_cnt  [4];
	logic [31:0] ch_aad  [4];
	logic [3:0]  ch_busy;
	logic [3:0]  ch_ack;
	logic [3:0]  ch_done;
	logic [3:0]  wr_ptr;
	logic [3:0]  wr_cnt;
	// decoded access
	logic        wr_acc;
	logic        rd_acc;
	logic        port;
	logic [13:0] off;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// set/clear shadow update; set wins over clear
	function automatic logic [1:0] set_clr(input logic [1:0] cur,
		input logic [1:0] set, input logic [1:0] clr);
		set_clr = (cur & ~clr) | set; // R7 R8
	endfunction : set_clr

	// write strobe for one offset of one port
	function automatic logic hit(input logic p, input logic [13:0] o);
		hit = wr_acc && (port == p) && (off == o);
	endfunction : hit

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	// word only: byte lanes dropped by clearing address bits 1:0
	assign off    = {paddr_i[13:2], 2'b00}; // R2
	assign port   = paddr_i[prt_pkg::WIN_BIT]; // R3
	assign wr_acc = psel_i && penable_i && pwrite_i; // R1
	assign rd_acc = psel_i && !penable_i && !pwrite_i;

	// pointer and counter write strobes per channel
	always_comb begin
		for (int c = 0; c < prt_pkg::CHANS; c++) begin
			wr_ptr[c] = hit(c[1], (c[0]) ? prt_pkg::OFF_TX_PTR
				: prt_pkg::OFF_RX_PTR); // R14
			wr_cnt[c] = hit(c[1], (c[0]) ? prt_pkg::OFF_TX_CNT
				: prt_pkg::OFF_RX_CNT); // R14
		end
	end

	// ---------------------------------------------------------------
	// channels
	// ---------------------------------------------------------------
	// one receiver and one transmitter channel per port
	for (genvar g = 0; g < prt_pkg::CHANS; g++) begin : g_ch
		prt_chan u_chan ( // R13
			.clk_sys_i  (clk_sys_i),
			.rst_i      (rst_i),
			.ce_i       (ce_i),
			.wr_ptr_i   (wr_ptr[g]),
			.wr_cnt_i   (wr_cnt[g]),
			.wdata_i    (pwdata_i),
			.en_i       (cfg_ff[g/2][g%2]),
			.req_i      (xfer_req_i[g]),
			.ptr_o      (ch_ptr[g]),
			.cnt_o      (ch_cnt[g]),
			.busy_o     (ch_busy[g]),
			.ack_o      (ch_ack[g]),
			.ack_addr_o (ch_aad[g]),
			.done_o     (ch_done[g])
		);
	end

	// ---------------------------------------------------------------
	// per-port control state
	// ---------------------------------------------------------------
	always_comb begin
		for (int p = 0; p < prt_pkg::PORTS; p++) begin
			// configuration: plain read/write
			nxt_cfg[p] = cfg_ff[p];
			if (hit(p[0], prt_pkg::OFF_CFG))
				nxt_cfg[p] = pwdata_i[1:0]; // R5
			// mask: only through set and clear registers
			nxt_msk[p] = set_clr(msk_ff[p],
				hit(p[0], prt_pkg::OFF_MSK_SET) ? pwdata_i[1:0] : 2'h0,
				hit(p[0], prt_pkg::OFF_MSK_CLR) ? pwdata_i[1:0] : 2'h0);
			// R12
			// end flags: set by channel done, cleared by command ones
			nxt_end[p] = set_clr(end_ff[p],
				{ch_done[2*p+1], ch_done[2*p]},
				hit(p[0], prt_pkg::OFF_CMD) ? pwdata_i[1:0] : 2'h0);
			// R4 R15
		end
	end

	// masked status ORed into one source per port
	always_comb begin
		for (int p = 0; p < prt_pkg::PORTS; p++)
			nxt_irq[p] = |(nxt_end[p] & nxt_msk[p]); // R10 R11 R15
	end

	// ---------------------------------------------------------------
	// read data, captured in the setup phase
	// ---------------------------------------------------------------
	always_comb begin
		nxt_rd = rd_ff;
		if (rd_acc) begin
			nxt_rd = prt_pkg::RD_ZERO; // R9
			case (off)
				prt_pkg::OFF_CFG:
					nxt_rd[1:0] = cfg_ff[port]; // R5
				prt_pkg::OFF_MSK:
					nxt_rd[1:0] = msk_ff[port]; // R12
				prt_pkg::OFF_STAT: begin
					nxt_rd[1:0] = end_ff[port]; // R6
					nxt_rd[prt_pkg::ST_RX_BUSY] = ch_busy[{port, 1'b0}];
					nxt_rd[prt_pkg::ST_TX_BUSY] = ch_busy[{port, 1'b1}];
				end
				prt_pkg::OFF_RX_PTR:
					nxt_rd = ch_ptr[{port, 1'b0}]; // R14
				prt_pkg::OFF_RX_CNT:
					nxt_rd[15:0] = ch_cnt[{port, 1'b0}];
				prt_pkg::OFF_TX_PTR:
					nxt_rd = ch_ptr[{port, 1'b1}];
				prt_pkg::OFF_TX_CNT:
					nxt_rd[15:0] = ch_cnt[{port, 1'b1}];
				// command, mask set/clear and holes read zero
				default: nxt_rd = prt_pkg::RD_ZERO; // R4 R9
			endcase
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			for (int p = 0; p < prt_pkg::PORTS; p++) begin
				cfg_ff[p] <= prt_pkg::CFG_RST; // R5
				msk_ff[p] <= prt_pkg::MSK_RST;
				end_ff[p] <= prt_pkg::STAT_RST;
			end
			irq_ff <= 2'h0;
			rd_ff  <= prt_pkg::RD_ZERO;
		end else if (ce_i) begin
			for (int p = 0; p < prt_pkg::PORTS; p++) begin
				cfg_ff[p] <= nxt_cfg[p];
				msk_ff[p] <= nxt_msk[p];
				end_ff[p] <= nxt_end[p];
			end
			irq_ff <= nxt_irq;
			rd_ff  <= nxt_rd;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all from flip-flops
	// ---------------------------------------------------------------
	assign prdata_o     = rd_ff;
	assign irq_src_o    = irq_ff;
	assign xfer_ack_o   = ch_ack;
	assign xfer_addr0_o = ch_aad[0];
	assign xfer_addr1_o = ch_aad[1];
	assign xfer_addr2_o = ch_aad[2];
	assign xfer_addr3_o = ch_aad[3];
endmodule : prt_regs

// *** prt_chan.sv ***
// package of shared constants and one transfer channel of the data controller
package prt_pkg;
	// ---------------------------------------------------------------
	// bus and window geometry
	// ---------------------------------------------------------------
	localparam int DATA_W        = 32;
	localparam int CNT_W         = 16;
	localparam int PORTS         = 2;
	localparam int CHANS         = 4;
	localparam int ADDR_W        = 15;
	localparam int WIN_BIT       = 14;
	localparam int OFF_W         = 14;
	localparam int PERIPH_WIN    = 16384;
	localparam int IC_WIN        = 4096;
	// ---------------------------------------------------------------
	// register offsets inside one port window
	// ---------------------------------------------------------------
	localparam logic [13:0] OFF_CMD      = 14'h0000;
	localparam logic [13:0] OFF_CFG      = 14'h0004;
	localparam logic [13:0] OFF_MSK_SET  = 14'h0008;
	localparam logic [13:0] OFF_MSK_CLR  = 14'h000C;
	localparam logic [13:0] OFF_MSK      = 14'h0010;
	localparam logic [13:0] OFF_STAT     = 14'h0014;
	localparam logic [13:0] OFF_RX_PTR   = 14'h0030;
	localparam logic [13:0] OFF_RX_CNT   = 14'h0034;
	localparam logic [13:0] OFF_TX_PTR   = 14'h0038;
	localparam logic [13:0] OFF_TX_CNT   = 14'h003C;
	// ---------------------------------------------------------------
	// field positions and reset values
	// ---------------------------------------------------------------
	localparam int CMD_CLR_RX_END = 0;
	localparam int CMD_CLR_TX_END = 1;
	localparam int CFG_RX_EN      = 0;
	localparam int CFG_TX_EN      = 1;
	localparam int ST_RX_END      = 0;
	localparam int ST_TX_END      = 1;
	localparam int ST_RX_BUSY     = 2;
	localparam int ST_TX_BUSY     = 3;
	localparam int FLG_W          = 2;
	localparam logic [1:0]  CFG_RST  = 2'h0;
	localparam logic [1:0]  MSK_RST  = 2'h0;
	localparam logic [1:0]  STAT_RST = 2'h0;
	localparam logic [31:0] PTR_RST  = 32'h0000_0000;
	localparam logic [15:0] CNT_RST  = 16'h0000;
	localparam logic [31:0] PTR_STEP = 32'h0000_0001;
	localparam logic [15:0] CNT_STEP = 16'h0001;
	localparam logic [31:0] RD_ZERO  = 32'h0000_0000;
	// channel state
	typedef enum logic {CH_IDLE, CH_RUN} prt_ch_t;
endpackage : prt_pkg

`timescale 1ns/100ps
module prt_chan (
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	// register writes
	input  wire logic        wr_ptr_i,
	input  wire logic        wr_cnt_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        en_i,
	// serial port request
	input  wire logic        req_i,
	// state out
	output logic      [31:0] ptr_o,
	output logic      [15:0] cnt_o,
	output logic             busy_o,
	output logic             ack_o,
	output logic      [31:0] ack_addr_o,
	output logic             done_o
);
	logic [31:0] ptr_ff, nxt_ptr;
	logic [15:0] cnt_ff, nxt_cnt;
	logic        ack_ff, nxt_ack;
	logic [31:0] aad_ff, nxt_aad;
	logic        done_ff, nxt_done;
	prt_pkg::prt_ch_t st_ff, nxt_st;

	// ---------------------------------------------------------------
	// next state: writes win over a transfer in the same cycle
	// ---------------------------------------------------------------
	always_comb begin
		nxt_ptr  = ptr_ff;
		nxt_cnt  = cnt_ff;
		nxt_ack  = 1'b0;
		nxt_aad  = aad_ff;
		nxt_done = 1'b0;
		nxt_st   = (cnt_ff != prt_pkg::CNT_RST && en_i) ?
			prt_pkg::CH_RUN : prt_pkg::CH_IDLE;
		case (st_ff)
			prt_pkg::CH_RUN: begin
				if (req_i && cnt_ff != prt_pkg::CNT_RST) begin
					nxt_ack  = 1'b1;
					nxt_aad  = ptr_ff;
					nxt_ptr  = ptr_ff + prt_pkg::PTR_STEP; // R16
					nxt_cnt  = cnt_ff - prt_pkg::CNT_STEP; // R16
					nxt_done = (cnt_ff == prt_pkg::CNT_STEP); // R15
				end
			end
			prt_pkg::CH_IDLE: begin
				nxt_ack = 1'b0; // R16
			end
			default: nxt_st = prt_pkg::CH_IDLE;
		endcase
		if (wr_ptr_i)
			nxt_ptr = wdata_i; // R14
		if (wr_cnt_i)
			nxt_cnt = wdata_i[15:0]; // R14
	end

	// register the channel
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			ptr_ff  <= prt_pkg::PTR_RST;
			cnt_ff  <= prt_pkg::CNT_RST;
			ack_ff  <= 1'b0;
			aad_ff  <= prt_pkg::PTR_RST;
			done_ff <= 1'b0;
			st_ff   <= prt_pkg::CH_IDLE;
		end else if (ce_i) begin
			ptr_ff  <= nxt_ptr;
			cnt_ff  <= nxt_cnt;
			ack_ff  <= nxt_ack;
			aad_ff  <= nxt_aad;
			done_ff <= nxt_done;
			st_ff   <= nxt_st;
		end
	end

	assign ptr_o      = ptr_ff;
	assign cnt_o      = cnt_ff;
	assign busy_o     = (st_ff == prt_pkg::CH_RUN);
	assign ack_o      = ack_ff;
	assign ack_addr_o = aad_ff;
	assign done_o     = done_ff;
endmodule : prt_chan

// *** prt_port_model.sv ***
// serial port request model driving the four transfer channels
`timescale 1ns/100ps
module prt_port_model (
	// clock
	input  wire logic       clk_sys_i,
	// request control from the bench
	input  wire logic [3:0] want_i,
	input  wire logic [3:0] slow_i,
	// requests into the channels
	output logic      [3:0] req_o
);
	logic ph_ff = 1'b0;

	// slow channels ask every other cycle, others hold the request
	always @(negedge clk_sys_i) begin
		ph_ff <= !ph_ff;
		req_o <= want_i & (~slow_i | {4{ph_ff}});
	end
endmodule : prt_port_model

// *** prt_regs_props.sv ***
// checker for the register bank, interrupt sources and channels
`timescale 1ns/100ps
module prt_regs_props (
	// clock and reset
	input wire logic        clk_sys_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	// peripheral bus
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [14:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	// channels and interrupts
	input wire logic [3:0]  xfer_req_i,
	input wire logic [3:0]  xfer_ack_o,
	input wire logic [31:0] xfer_addr0_o,
	input wire logic [31:0] xfer_addr1_o,
	input wire logic [31:0] xfer_addr2_o,
	input wire logic [31:0] xfer_addr3_o,
	input wire logic [1:0]  irq_src_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	logic rd_s;
	logic wr_a;

	// read setup and write access phases
	assign rd_s = psel_i && !penable_i && !pwrite_i && ce_i;
	assign wr_a = psel_i && penable_i && pwrite_i && ce_i;

	ack_cause_a: assert property (
		xfer_ack_o[0] |-> $past(xfer_req_i[0]))
		else $error("ack without request");
	addr_step_a: assert property (
		xfer_ack_o[0] && $past(xfer_ack_o[0]) |->
		xfer_addr0_o == $past(xfer_addr0_o) + 32'h0000_0001)
		else $error("pointer did not step by one");
	addr_hold_a: assert property (
		!xfer_ack_o[3] |-> $stable(xfer_addr3_o))
		else $error("transfer address moved without ack");
	rsvd_zero_a: assert property (
		rd_s && paddr_i[13:0] < 14'h0030 |=> prdata_o[31:4] == 28'h0)
		else $error("unused bits not zero");
	unmapped_a: assert property (
		rd_s && paddr_i[13:2] == 12'h008 |=> prdata_o == 32'h0)
		else $error("unmapped read not zero");
	mask_clr_a: assert property (
		wr_a && paddr_i == 15'h000C && pwdata_i[1:0] == 2'h3
		|=> !irq_src_o[0])
		else $error("interrupt after full mask clear");
	disable_stop_a: assert property (
		wr_a && paddr_i == 15'h0004 && !pwdata_i[0]
		|-> ##4 !xfer_ack_o[0] [*3])
		else $error("transfer while disabled");
	cnt_zero_a: assert property (
		wr_a && paddr_i == 15'h0034 && pwdata_i[15:0] == 16'h0
		|-> ##4 !xfer_ack_o[0] [*3])
		else $error("transfer with zero count");
endmodule : prt_regs_props

bind prt_regs prt_regs_props u_props (.clk_sys_i(clk_sys_i),
	.rst_i(rst_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.prdata_o(prdata_o), .xfer_req_i(xfer_req_i), .xfer_ack_o(xfer_ack_o),
	.xfer_addr0_o(xfer_addr0_o), .xfer_addr1_o(xfer_addr1_o),
	.xfer_addr2_o(xfer_addr2_o), .xfer_addr3_o(xfer_addr3_o),
	.irq_src_o(irq_src_o));

// *** prt_regs_tb_top.sv ***
// self-checking bench for the register bank and transfer channels
`timescale 1ns/100ps
module prt_regs_tb_top;
	logic        clk_sys_i;
	logic        rst_i;
	logic        psel_i;
	logic        penable_i;
	logic        pwrite_i;
	logic [14:0] paddr_i;
	logic [31:0] pwdata_i;
	logic [31:0] prdata_o;
	logic [31:0] a0;
	logic [31:0] a1;
	logic [31:0] a2;
	logic [31:0] a3;
	logic [3:0]  req;
	logic [3:0]  ack;
	logic [3:0]  want;
	logic [3:0]  slow;
	logic [1:0]  irq;
	int          err_count;
	int          checks_done;
	int          cyc;
	int          n_ack0;
	int          n_hold;

	prt_regs u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.xfer_req_i(req), .xfer_ack_o(ack), .xfer_addr0_o(a0),
		.xfer_addr1_o(a1), .xfer_addr2_o(a2), .xfer_addr3_o(a3),
		.irq_src_o(irq));
	prt_port_model u_port (.clk_sys_i(clk_sys_i), .want_i(want),
		.slow_i(slow), .req_o(req));

	// clock, cycle ceiling and ack counter
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			print_verdict();
		end
	end
	always @(negedge clk_sys_i) if (ack[0] === 1'b1) n_ack0++;

	task automatic chk(input string what, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// bus write: setup, access, idle
	task automatic wr(input logic [14:0] a, input logic [31:0] d);
		@(negedge clk_sys_i);
		psel_i = 1'b1;
		pwrite_i = 1'b1;
		paddr_i = a;
		pwdata_i = d;
		@(negedge clk_sys_i);
		penable_i = 1'b1;
		@(negedge clk_sys_i);
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
	endtask : wr

	// bus read, data compared during the access phase
	task automatic rd(input logic [14:0] a, input logic [31:0] e,
		input string what);
		@(negedge clk_sys_i);
		psel_i = 1'b1;
		paddr_i = a;
		@(negedge clk_sys_i);
		penable_i = 1'b1;
		chk(what, prdata_o, e);
		@(negedge clk_sys_i);
		psel_i = 1'b0;
		penable_i = 1'b0;
	endtask : rd

	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict

	// main sequence
	initial begin
		rst_i = 1'b1;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 15'h0000;
		pwdata_i = 32'h0000_0000;
		want = 4'h0;
		slow = 4'h8;
		repeat (5) @(negedge clk_sys_i);
		rst_i = 1'b0;
		rd(15'h0004, 32'h0, "cfg reset");
		rd(15'h0010, 32'h0, "mask reset");
		rd(15'h0030, 32'h0, "pointer reset");
		wr(15'h0004, 32'h2);
		rd(15'h0004, 32'h2, "cfg rw");
		wr(15'h0006, 32'h1);
		rd(15'h0004, 32'h1, "cfg word access");
		wr(15'h4004, 32'h2);
		rd(15'h4004, 32'h2, "port1 cfg");
		rd(15'h0004, 32'h1, "port0 cfg kept");
		rd(15'h0020, 32'h0, "unmapped");
		rd(15'h0000, 32'h0, "cmd read");
		wr(15'h0008, 32'h3);
		rd(15'h0010, 32'h3, "mask set");
		wr(15'h000C, 32'h1);
		rd(15'h0010, 32'h2, "mask clear");
		wr(15'h0010, 32'h1);
		rd(15'h0010, 32'h2, "mask direct");
		wr(15'h000C, 32'h3);
		rd(15'h0010, 32'h0, "mask all clear");
		wr(15'h0014, 32'h3);
		rd(15'h0014, 32'h0, "status ro");
		wr(15'h0030, 32'h100);
		wr(15'h0034, 32'h3);
		wr(15'h0008, 32'h1);
		want <= 4'h1;
		for (int i = 0; i < 40 && n_ack0 < 3; i++) @(negedge clk_sys_i);
		repeat (3) @(negedge clk_sys_i);
		chk("rx acks", 32'(n_ack0), 32'h3);
		chk("rx last addr", a0, 32'h102);
		rd(15'h0030, 32'h103, "rx pointer");
		rd(15'h0034, 32'h0, "rx count");
		rd(15'h0014, 32'h1, "rx end flag");
		chk("irq rx", {30'h0, irq}, 32'h1);
		wr(15'h0000, 32'h0);
		rd(15'h0014, 32'h1, "cmd zero");
		wr(15'h0000, 32'h1);
		rd(15'h0014, 32'h0, "cmd clear");
		chk("irq cleared", {30'h0, irq}, 32'h0);
		wr(15'h4038, 32'h200);
		wr(15'h403C, 32'h2);
		want <= 4'h9;
		for (int i = 0; i < 40 && a3 !== 32'h201; i++) @(negedge clk_sys_i);
		repeat (3) @(negedge clk_sys_i);
		rd(15'h4014, 32'h2, "tx end flag");
		chk("irq masked", {30'h0, irq}, 32'h0);
		wr(15'h4008, 32'h2);
		chk("irq tx", {30'h0, irq}, 32'h2);
		chk("rx stopped", 32'(n_ack0), 32'h3);
		// port0 tx and port1 rx channels, one transfer each
		wr(15'h0038, 32'h300);
		wr(15'h003C, 32'h1);
		wr(15'h4030, 32'h400);
		wr(15'h4034, 32'h1);
		wr(15'h0004, 32'h3);
		wr(15'h4004, 32'h3);
		want <= 4'hF;
		repeat (6) @(negedge clk_sys_i);
		chk("port0 tx addr", a1, 32'h300);
		chk("port1 rx addr", a2, 32'h400);
		rd(15'h0014, 32'h2, "port0 tx end");
		rd(15'h4014, 32'h3, "port1 both ends");
		chk("irq port1 only", {30'h0, irq}, 32'h2);
		// disable a running channel, then re-enable it
		wr(15'h0034, 32'h10);
		repeat (4) @(negedge clk_sys_i);
		wr(15'h0004, 32'h2);
		repeat (4) @(negedge clk_sys_i);
		n_hold = n_ack0;
		repeat (8) @(negedge clk_sys_i);
		chk("rx disabled", 32'(n_ack0), 32'(n_hold));
		wr(15'h0004, 32'h3);
		repeat (4) @(negedge clk_sys_i);
		chk("rx resumed", 32'(n_ack0 > n_hold), 32'h1);
		// zero count written while running stops the channel
		wr(15'h0034, 32'h0);
		repeat (4) @(negedge clk_sys_i);
		n_hold = n_ack0;
		repeat (8) @(negedge clk_sys_i);
		chk("rx zero count", 32'(n_ack0), 32'(n_hold));
		rd(15'h0034, 32'h0, "count write wins");
		print_verdict();
	end
endmodule : prt_regs_tb_top
